/* File: pkg/tas_consts.svh */
// Register offsets, field positions, reset values and timing counts of the async timer
`ifndef TAS_CONSTS_SVH
`define TAS_CONSTS_SVH
`define TAS_IDX_FLAG_STATUS 8'h17
`define TAS_IDX_IRQ_MASK 8'h70
`define TAS_IDX_COUNTER 8'h20
`define TAS_IDX_COMPARE_A 8'h21
`define TAS_IDX_COMPARE_B 8'h22
`define TAS_IDX_CONTROL_A 8'h23
`define TAS_IDX_CONTROL_B 8'h24
`define TAS_IDX_ASYNC_STATUS 8'h25
`define TAS_HOLD_COUNTER 0
`define TAS_HOLD_COMPARE_A 1
`define TAS_HOLD_COMPARE_B 2
`define TAS_HOLD_CONTROL_A 3
`define TAS_HOLD_CONTROL_B 4
`define TAS_BIT_OVERFLOW 0
`define TAS_BIT_COMPARE_A 1
`define TAS_BIT_COMPARE_B 2
`define TAS_BIT_ASYNC_SELECT 5
`define TAS_BIT_UPDOWN_MODE 0
`define TAS_BIT_PIN_A_TOGGLE 6
`define TAS_BIT_PIN_B_TOGGLE 4
`define TAS_CLKSEL_MSB 2
`define TAS_RESET_BYTE 8'h00
`define TAS_COUNT_MAX 8'hFF
`define TAS_COUNT_MIN 8'h00
`define TAS_SYNC_TICKS 2'h2
`define TAS_FLAG_SYNC_CYCLES 3
`define TAS_HALT_CYCLES 3'h4
`endif

/* File: pkg/tas_pkg.sv */
// Types shared by the async timer design
package tas_pkg;
  typedef enum logic [2:0] {
    TAS_AWAKE = 3'b001,
    TAS_ASLEEP = 3'b010,
    TAS_HALTED = 3'b100
  } tas_power_e;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tas_apb_rsp_s;

  typedef struct packed {
    logic [4:0][7:0] hold;
    logic [4:0][7:0] dest;
    logic [4:0] busy;
    logic [4:0][1:0] tick_cnt;
    logic [7:0] counter_copy;
    logic count_down;
    logic async_sel;
    logic [2:0] irq_mask;
    logic [2:0] flags;
    logic [2:0] ev_wait;
    logic [2:0][2:0] ev_pipe;
    logic pin_a;
    logic pin_b;
    logic pin_prev;
    logic wake_cond;
    logic rearmed;
    logic wake;
    logic halt;
    logic [2:0] halt_cnt;
    tas_power_e power;
    logic [2:0] irq_req;
    tas_apb_rsp_s rsp;
  } tas_state_s;
endpackage

/* File: design/tas_sync.sv */
// Two-flop synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module tas_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: design/tas_timer.sv */
// Async-clocked 8-bit timer: holding registers, busy flags, read copy, flags, wake-up
`timescale 1ns/1ps
`default_nettype none
`include "tas_consts.svh"
module tas_timer
  import tas_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Processor side
  input wire logic i_global_irq_enable,
  input wire logic [2:0] i_vector_ack,
  input wire logic i_sleep_power_save,
  input wire logic i_power_down,
  output logic [2:0] o_irq_request,
  output logic o_wake_request,
  output logic o_cpu_halt,
  // Timer pins
  input wire logic i_async_clock_pin,
  output logic o_compare_a_pin,
  output logic o_compare_b_pin
);
  tas_state_s s;
  tas_state_s next_s;
  logic pin_sync;
  logic tick;
  logic running;
  logic [2:0] events;
  logic [2:0] flag_clear;
  logic apb_access;
  logic apb_write;
  logic [7:0] sel_idx;

  // Index of the word addressed on the bus
  function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
    reg_index = addr[9:2];
  endfunction

  // Holding slot for an index, or 7 when not a cross-domain register
  function automatic logic [2:0] hold_slot(input logic [7:0] idx);
    case (idx)
      `TAS_IDX_COUNTER: hold_slot = 3'h0;
      `TAS_IDX_COMPARE_A: hold_slot = 3'h1;
      `TAS_IDX_COMPARE_B: hold_slot = 3'h2;
      `TAS_IDX_CONTROL_A: hold_slot = 3'h3;
      `TAS_IDX_CONTROL_B: hold_slot = 3'h4;
      default: hold_slot = 3'h7;
    endcase
  endfunction

  tas_sync #(.WIDTH(1)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_async_clock_pin),
    .o_sync(pin_sync)
  );

  // Oscillator is dead in power-down, so in async mode no tick reaches the counter
  assign tick = s.async_sel ? (pin_sync & ~s.pin_prev & ~i_power_down) : 1'b1;
  assign running = s.dest[`TAS_HOLD_CONTROL_B][`TAS_CLKSEL_MSB:0] != 3'h0;
  assign apb_access = i_psel & i_penable & s.rsp.pready;
  assign apb_write = apb_access & i_pwrite;
  assign sel_idx = reg_index(i_paddr);
  assign flag_clear = i_vector_ack |
    ((apb_write && sel_idx == `TAS_IDX_FLAG_STATUS) ? i_pwdata[2:0] : 3'h0);

  always_comb begin
    logic [2:0] slot;
    logic [7:0] cnt;
    logic hit_a;
    logic hit_b;
    logic ovf;
    slot = hold_slot(sel_idx);
    cnt = s.dest[`TAS_HOLD_COUNTER];
    hit_a = 1'b0;
    hit_b = 1'b0;
    ovf = 1'b0;
    next_s = s;
    next_s.pin_prev = pin_sync;
    next_s.wake = 1'b0;

    // Holding registers: each slot runs its own two-tick load
    for (int i = 0; i < 5; i++) begin
      if (s.busy[i] && tick) begin
        if (s.tick_cnt[i] == `TAS_SYNC_TICKS - 2'h1) begin
          next_s.dest[i] = s.hold[i];
          next_s.busy[i] = 1'b0;
          next_s.tick_cnt[i] = 2'h0;
        end else begin
          next_s.tick_cnt[i] = s.tick_cnt[i] + 2'h1;
        end
      end
    end

    // Counter and compare logic on the timer tick
    events = 3'h0;
    if (tick && running && !(s.busy[`TAS_HOLD_COUNTER] && s.tick_cnt[0] != 2'h0 && tick
        && s.tick_cnt[0] == `TAS_SYNC_TICKS - 2'h1)) begin
      hit_a = (cnt == s.dest[`TAS_HOLD_COMPARE_A]) &&
        !(s.busy[`TAS_HOLD_COUNTER] || s.busy[`TAS_HOLD_COMPARE_A]);
      hit_b = (cnt == s.dest[`TAS_HOLD_COMPARE_B]) &&
        !(s.busy[`TAS_HOLD_COUNTER] || s.busy[`TAS_HOLD_COMPARE_B]);
      if (s.dest[`TAS_HOLD_CONTROL_A][`TAS_BIT_UPDOWN_MODE]) begin
        if (s.count_down && cnt == `TAS_COUNT_MIN) begin
          next_s.count_down = 1'b0;
          next_s.dest[`TAS_HOLD_COUNTER] = cnt + 8'h01;
          ovf = 1'b1;
        end else if (!s.count_down && cnt == `TAS_COUNT_MAX) begin
          next_s.count_down = 1'b1;
          next_s.dest[`TAS_HOLD_COUNTER] = cnt - 8'h01;
        end else begin
          next_s.dest[`TAS_HOLD_COUNTER] = s.count_down ? cnt - 8'h01 : cnt + 8'h01;
        end
      end else begin
        next_s.dest[`TAS_HOLD_COUNTER] = cnt + 8'h01;
        ovf = (cnt == `TAS_COUNT_MAX);
      end
      if (hit_a && s.dest[`TAS_HOLD_CONTROL_A][`TAS_BIT_PIN_A_TOGGLE]) begin
        next_s.pin_a = ~s.pin_a;
      end
      if (hit_b && s.dest[`TAS_HOLD_CONTROL_A][`TAS_BIT_PIN_B_TOGGLE]) begin
        next_s.pin_b = ~s.pin_b;
      end
    end
    events[`TAS_BIT_OVERFLOW] = ovf;
    events[`TAS_BIT_COMPARE_A] = hit_a;
    events[`TAS_BIT_COMPARE_B] = hit_b;

    // Read copy follows the counter each tick, but not while asleep
    if (tick && s.power != TAS_ASLEEP) begin
      next_s.counter_copy = s.dest[`TAS_HOLD_COUNTER];
    end

    // Flag crossing: wait one tick, then three core cycles
    next_s.ev_pipe[1] = s.ev_pipe[0];
    next_s.ev_pipe[2] = s.ev_pipe[1];
    next_s.ev_pipe[0] = 3'h0;
    if (s.async_sel) begin
      if (tick) begin
        next_s.ev_pipe[0] = s.ev_wait;
        next_s.ev_wait = events;
      end
      next_s.flags = (s.flags & ~flag_clear) | s.ev_pipe[2];
    end else begin
      next_s.ev_wait = 3'h0;
      next_s.flags = (s.flags & ~flag_clear) | events | s.ev_pipe[2];
    end
    next_s.irq_req = s.irq_mask & s.flags & {3{i_global_irq_enable}};

    // Sleep and wake sequencing
    case (s.power)
      TAS_AWAKE: begin
        if (tick) begin
          next_s.rearmed = 1'b1;
        end
        if (i_sleep_power_save) begin
          next_s.power = TAS_ASLEEP;
          next_s.wake_cond = 1'b0;
        end
      end
      TAS_ASLEEP: begin
        if (s.rearmed && (s.irq_req != 3'h0)) begin
          next_s.wake_cond = 1'b1;
        end
        if (s.wake_cond && tick) begin
          next_s.power = TAS_HALTED;
          next_s.wake = 1'b1;
          next_s.rearmed = 1'b0;
          next_s.halt_cnt = 3'h0;
        end
      end
      TAS_HALTED: begin
        next_s.halt_cnt = s.halt_cnt + 3'h1;
        if (s.halt_cnt == `TAS_HALT_CYCLES - 3'h1) begin
          next_s.power = TAS_AWAKE;
        end
      end
      default: begin
        next_s.power = TAS_AWAKE;
      end
    endcase
    next_s.halt = (next_s.power == TAS_HALTED);

    // Register writes, at the completing access edge only
    if (apb_write) begin
      if (slot != 3'h7) begin
        next_s.hold[slot] = i_pwdata[7:0];
        if (s.async_sel) begin
          next_s.busy[slot] = 1'b1;
          next_s.tick_cnt[slot] = 2'h0;
        end else begin
          next_s.dest[slot] = i_pwdata[7:0];
        end
      end else if (sel_idx == `TAS_IDX_IRQ_MASK) begin
        next_s.irq_mask = i_pwdata[2:0];
      end else if (sel_idx == `TAS_IDX_ASYNC_STATUS) begin
        next_s.async_sel = i_pwdata[`TAS_BIT_ASYNC_SELECT];
      end
    end

    // Answer with one wait state so the response comes from flops
    next_s.rsp.pready = i_psel & i_penable & ~s.rsp.pready;
    next_s.rsp.pslverr = 1'b0;
    next_s.rsp.prdata = 32'h0000_0000;
    if (i_psel && i_penable && !s.rsp.pready) begin
      case (sel_idx)
        `TAS_IDX_COUNTER: next_s.rsp.prdata[7:0] = s.counter_copy;
        `TAS_IDX_COMPARE_A: next_s.rsp.prdata[7:0] = s.hold[1];
        `TAS_IDX_COMPARE_B: next_s.rsp.prdata[7:0] = s.hold[2];
        `TAS_IDX_CONTROL_A: next_s.rsp.prdata[7:0] = s.hold[3];
        `TAS_IDX_CONTROL_B: next_s.rsp.prdata[7:0] = s.hold[4];
        `TAS_IDX_FLAG_STATUS: next_s.rsp.prdata[2:0] = s.flags;
        `TAS_IDX_IRQ_MASK: next_s.rsp.prdata[2:0] = s.irq_mask;
        `TAS_IDX_ASYNC_STATUS: next_s.rsp.prdata[5:0] =
          {s.async_sel, s.busy[0], s.busy[1], s.busy[2], s.busy[3], s.busy[4]};
        default: next_s.rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
      s.power <= TAS_AWAKE;
    end else begin
      s <= next_s;
    end
  end

  assign o_prdata = s.rsp.prdata;
  assign o_pready = s.rsp.pready;
  assign o_pslverr = s.rsp.pslverr;
  assign o_irq_request = s.irq_req;
  assign o_wake_request = s.wake;
  assign o_cpu_halt = s.halt;
  assign o_compare_a_pin = s.pin_a;
  assign o_compare_b_pin = s.pin_b;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  busy_set_a: assert property (
    (apb_write && s.async_sel && sel_idx == `TAS_IDX_COMPARE_A) |=> s.busy[1])
    else $error("busy flag not set by async write");
  load_two_ticks_a: assert property (
    $fell(s.busy[1]) |-> $past(tick) && $past(s.tick_cnt[1]) == 2'h1)
    else $error("holding register loaded without two ticks");
  hold_isolated_a: assert property (
    (apb_write && sel_idx == `TAS_IDX_COUNTER) |=> s.hold[1] == $past(s.hold[1]))
    else $error("counter write disturbed compare holding register");
  match_blocked_a: assert property (
    (s.busy[1] && s.busy[1] == $past(s.busy[1])) |-> !events[`TAS_BIT_COMPARE_A])
    else $error("compare matched while write pending");
  irq_gate_a: assert property (
    ##1 o_irq_request == ($past(s.irq_mask) & $past(s.flags) & {3{$past(i_global_irq_enable)}}))
    else $error("interrupt request not gated correctly");
  flag_clear_a: assert property (
    (flag_clear[0] && !events[0] && !s.ev_pipe[2][0]) |=> !s.flags[0])
    else $error("write one did not clear flag");
  halt_four_a: assert property (
    $rose(s.halt) |-> s.halt [*4] ##1 !s.halt)
    else $error("halt not four cycles");
  copy_frozen_a: assert property (
    (s.power == TAS_ASLEEP) |=> s.counter_copy == $past(s.counter_copy))
    else $error("read copy changed during sleep");
  flag_delay_a: assert property (
    (s.async_sel && s.ev_pipe[0][1]) |-> ##2 s.ev_pipe[2][1] ##1 s.flags[1])
    else $error("flag crossing delay wrong");
  pin_on_tick_a: assert property (
    (s.pin_a != $past(s.pin_a)) |-> $past(tick))
    else $error("compare pin changed off tick");
  wake_on_tick_a: assert property (
    $rose(s.wake) |-> $past(tick) && $past(s.wake_cond))
    else $error("wake not on timer tick");
endmodule
`default_nettype wire

/* File: sim/tas_osc_model.sv */
// Free-running low-frequency oscillator that drives the timer's clock pin
`timescale 1ns/1ps
`default_nettype none
module tas_osc_model #(
  parameter int HALF_NS = 50
) (
  // Sleep state
  input wire logic i_power_down,
  // Oscillator pin
  output logic o_pin
);
  // Odd start offset keeps pin edges off the core clock edges
  // Model is stable from time zero, so the settle wait is met at once
  initial begin
    o_pin = 1'b0;
    #13;
    forever begin
      #HALF_NS;
      // Period of 25 core cycles stays well above four core cycles
      if (!i_power_down) begin
        o_pin = ~o_pin; // Oscillator halts in power-down
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/tas_timer_tb.sv */
// Self-checking testbench of the async timer over APB
`timescale 1ns/1ps
`default_nettype none
`include "tas_consts.svh"
`define TB_CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module tas_timer_tb;
  localparam logic [7:0] FS = `TAS_IDX_FLAG_STATUS;
  localparam logic [7:0] IM = `TAS_IDX_IRQ_MASK;
  localparam logic [7:0] CNT = `TAS_IDX_COUNTER;
  localparam logic [7:0] CA = `TAS_IDX_COMPARE_A;
  localparam logic [7:0] CB = `TAS_IDX_COMPARE_B;
  localparam logic [7:0] CTA = `TAS_IDX_CONTROL_A;
  localparam logic [7:0] CTB = `TAS_IDX_CONTROL_B;
  localparam logic [7:0] AST = `TAS_IDX_ASYNC_STATUS;
  logic clk, rst_n, psel, penable, pwrite, gie, sleep, pdown, pin, pready, err_o, wake, halt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] vack, irq;
  logic cmp_a, cmp_b;
  logic err;
  int miscompares, total_checks;

  tas_osc_model i_osc (.i_power_down(pdown), .o_pin(pin));

  tas_timer #(.ADDR_WIDTH(12)) i_dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(err_o), .i_global_irq_enable(gie),
    .i_vector_ack(vack), .i_sleep_power_save(sleep), .i_power_down(pdown),
    .o_irq_request(irq), .o_wake_request(wake), .o_cpu_halt(halt),
    .i_async_clock_pin(pin), .o_compare_a_pin(cmp_a), .o_compare_b_pin(cmp_b)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    err = err_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded register poll until masked bits reach the expected value
  task automatic poll(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] ex);
    int n;
    n = 0;
    do begin
      apb(1'b0, idx, 8'h00);
      n++;
    end while ((rd[7:0] & m) !== ex && n < 200);
    `TB_CHK("poll", ex, rd[7:0] & m)
    if ((rd[7:0] & m) !== ex) end_of_test();
  endtask

  initial begin
    int n;
    {rst_n, psel, penable, pwrite, gie, sleep, pdown} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    vack = 3'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, FS, 8'h00);
    `TB_CHK("flag_status", 32'h00000000, rd)
    apb(1'b0, IM, 8'h00);
    `TB_CHK("irq_mask", 32'h00000000, rd)
    apb(1'b1, IM, 8'hFF);
    apb(1'b0, IM, 8'h00);
    `TB_CHK("irq_mask", 32'h00000007, rd)
    apb(1'b1, IM, 8'h00);
    apb(1'b0, 8'h30, 8'h00);
    `TB_CHK("unmapped_err", 1'b1, err)
    `TB_CHK("unmapped_data", 32'h00000000, rd)
    $display("test registers done");
    // Core-clocked counting sets both compare flags and overflow
    apb(1'b1, CA, 8'h05);
    apb(1'b1, CTB, 8'h01);
    poll(FS, 8'h07, 8'h07);
    apb(1'b1, CTB, 8'h00);
    apb(1'b1, CNT, 8'h80);
    apb(1'b1, FS, 8'h00);
    apb(1'b0, FS, 8'h00);
    `TB_CHK("flag_status", 32'h00000007, rd)
    apb(1'b1, FS, 8'h02);
    apb(1'b0, FS, 8'h00);
    `TB_CHK("flag_status", 32'h00000005, rd)
    $display("test sync flags done");
    apb(1'b1, IM, 8'h01);
    gie <= 1'b1;
    repeat (3) @(posedge clk);
    `TB_CHK("irq_request", 3'b001, irq)
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    `TB_CHK("irq_request", 3'b000, irq)
    vack <= 3'b001;
    @(posedge clk);
    vack <= 3'b000;
    apb(1'b0, FS, 8'h00);
    `TB_CHK("flag_status", 32'h00000004, rd)
    apb(1'b1, FS, 8'h04);
    apb(1'b0, FS, 8'h00);
    `TB_CHK("flag_status", 32'h00000000, rd)
    $display("test interrupts done");
    // One match on each compare during a short run toggles each pin
    apb(1'b1, CNT, 8'h04);
    apb(1'b1, CB, 8'h06);
    apb(1'b1, CTA, 8'h50);
    apb(1'b1, CTB, 8'h01);
    apb(1'b1, CTB, 8'h00);
    `TB_CHK("compare_a_pin", 1'b1, cmp_a)
    `TB_CHK("compare_b_pin", 1'b1, cmp_b)
    // Up-down run turns at the top with no overflow, then flags the turn at zero
    apb(1'b1, CNT, 8'hFD);
    apb(1'b1, CTA, 8'h01);
    apb(1'b1, FS, 8'h07);
    apb(1'b1, CTB, 8'h01);
    apb(1'b1, CTB, 8'h00);
    apb(1'b0, CNT, 8'h00);
    `TB_CHK("counter_updown", 32'h000000FD, rd)
    apb(1'b0, FS, 8'h00);
    `TB_CHK("flag_status", 32'h00000000, rd)
    apb(1'b1, CTB, 8'h01);
    poll(FS, 8'h01, 8'h01);
    apb(1'b1, CTB, 8'h00);
    apb(1'b1, CTA, 8'h00);
    $display("test pins and up-down done");
    // Two pending writes must each show their own busy bit
    apb(1'b1, IM, 8'h00);
    apb(1'b1, AST, 8'h20);
    apb(1'b0, AST, 8'h00);
    `TB_CHK("async_status", 32'h00000020, rd)
    apb(1'b1, CNT, 8'hF0);
    apb(1'b1, CB, 8'h33);
    apb(1'b0, AST, 8'h00);
    `TB_CHK("async_status", 32'h00000034, rd)
    apb(1'b0, CB, 8'h00);
    `TB_CHK("compare_b", 32'h00000033, rd)
    poll(AST, 8'h1F, 8'h00);
    $display("test async writes done");
    // Stopped oscillator in power-down leaves a pending load waiting
    pdown <= 1'b1;
    apb(1'b1, CA, 8'h05);
    repeat (120) @(posedge clk);
    apb(1'b0, AST, 8'h00);
    `TB_CHK("async_status", 32'h00000028, rd)
    pdown <= 1'b0;
    poll(AST, 8'h1F, 8'h00);
    apb(1'b1, CTB, 8'h01);
    poll(AST, 8'h1F, 8'h00);
    apb(1'b1, FS, 8'h07);
    apb(1'b1, IM, 8'h01);
    gie <= 1'b1;
    sleep <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wake !== 1'b1 && n < 3000);
    `TB_CHK("wake_request", 1'b1, wake)
    if (wake !== 1'b1) end_of_test();
    // Processor leaves sleep on wake, so the read copy may follow again
    sleep <= 1'b0;
    n = (halt === 1'b1) ? 1 : 0;
    repeat (12) begin
      @(posedge clk);
      if (halt === 1'b1) n++;
    end
    `TB_CHK("halt_cycles", 4, n)
    `TB_CHK("irq_request", 3'b001, irq)
    // Counter read after wake: rewrite a compare, wait for its load, then read
    apb(1'b1, CA, 8'h05);
    poll(AST, 8'h08, 8'h00);
    apb(1'b0, CNT, 8'h00);
    `TB_CHK("counter_advanced", 1'b1, rd[7:0] != 8'h00 && rd[7:0] < 8'h08)
    $display("test wake done");
    end_of_test();
  end
endmodule
`default_nettype wire
